// *** hw/tbp_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tbp_params.svh"
module tbp_timer (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire tbp_pkg::tbp_bus_req_t avs_req,
    output tbp_pkg::tbp_bus_rsp_t      avs_rsp,
    input  wire logic                  ext_count_input,
    output tbp_pkg::tbp_pin_t          pin
);
    import tbp_pkg::*;

    typedef struct packed {
        tbp_mode_t    mode;
        logic [7:0]   count_value;
        logic [7:0]   reload_compare_value;
        logic         overflow_irq_flag;
        logic         overflow_irq_enable;
        logic         toggle_lvl;
        logic         pwm_lvl;
        tbp_bus_rsp_t rsp;
        tbp_pin_t     pin;
    } tbp_state_t;

    tbp_state_t st_ff;
    tbp_state_t nxt_st;

    logic pre_tick;
    logic ext_fall;

    function automatic logic [7:0] range_mask(input tbp_mode_t m);
        if (!m.pwm_output_enable) begin
            return `TBP_MASK_256;
        end
        unique case ({m.reload_or_range_bit, m.timer_toggle_out})
            2'h0: return `TBP_MASK_256;
            2'h1: return `TBP_MASK_64;
            2'h2: return `TBP_MASK_32;
            2'h3: return `TBP_MASK_16;
        endcase
    endfunction

    tbp_prescaler u_pre (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .run     (st_ff.mode.counter_enable && !st_ff.mode.clock_source_select),
        .rate    (st_ff.mode.prescale_select),
        .tick    (pre_tick)
    );

    tbp_sync u_ext (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin_in  (ext_count_input),
        .fall    (ext_fall)
    );

    logic       req;
    logic       accept;
    logic       wr_lane0;
    logic       tick;
    logic       wrap;
    logic       flag_set;
    logic [7:0] mask;
    logic [7:0] cur;
    logic [7:0] rd;
    logic [7:0] wr_byte;

    assign req      = avs_req.read || avs_req.write;
    assign wr_byte  = avs_req.writedata[7:0];
    // request is served on the edge where waitrequest is low
    assign accept   = req && !st_ff.rsp.waitrequest;
    assign wr_lane0 = accept && avs_req.write && avs_req.byteenable[0];
    assign mask     = range_mask(st_ff.mode);
    assign cur      = st_ff.count_value & mask;
    assign tick     = st_ff.mode.counter_enable &&
                      (st_ff.mode.clock_source_select ? ext_fall : pre_tick);

    always_comb begin
        rd = 8'h00;
        unique case (avs_req.address)
            `TBP_ADDR_MODE:   rd = st_ff.mode;
            `TBP_ADDR_COUNT:  rd = st_ff.count_value;
            `TBP_ADDR_IRQ: begin
                rd[`TBP_IRQ_FLAG_BIT] = st_ff.overflow_irq_flag;
                rd[`TBP_IRQ_EN_BIT]   = st_ff.overflow_irq_enable;
            end
            `TBP_ADDR_STATUS: begin
                rd[`TBP_ST_TOGGLE_BIT] = st_ff.toggle_lvl;
                rd[`TBP_ST_PWM_BIT]    = st_ff.pwm_lvl;
                rd[`TBP_ST_PIN_BIT]    = st_ff.pin.pin_out;
            end
            // compare register is write-only and reads as zero
            default:          rd = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st                  = st_ff;
        wrap                    = 1'h0;
        nxt_st.rsp.waitrequest  = !(req && st_ff.rsp.waitrequest);
        if (req && st_ff.rsp.waitrequest) begin
            nxt_st.rsp.readdata = {24'h000000, rd};
        end

        if (wr_lane0 && avs_req.address == `TBP_ADDR_MODE) begin
            nxt_st.mode = avs_req.writedata[7:0];
        end
        if (wr_lane0 && avs_req.address == `TBP_ADDR_COMPARE) begin
            nxt_st.reload_compare_value = avs_req.writedata[7:0];
        end
        if (wr_lane0 && avs_req.address == `TBP_ADDR_IRQ) begin
            nxt_st.overflow_irq_flag   = avs_req.writedata[`TBP_IRQ_FLAG_BIT];
            nxt_st.overflow_irq_enable = avs_req.writedata[`TBP_IRQ_EN_BIT];
        end

        // a software write wins over a counting tick in the same cycle
        if (wr_lane0 && avs_req.address == `TBP_ADDR_COUNT) begin
            nxt_st.count_value = avs_req.writedata[7:0] & mask;
        end else if (tick) begin
            if (cur == mask) begin
                wrap = 1'h1;
                if (!st_ff.mode.pwm_output_enable && st_ff.mode.reload_or_range_bit) begin
                    nxt_st.count_value = st_ff.reload_compare_value;
                end else begin
                    nxt_st.count_value = 8'h00;
                end
            end else begin
                nxt_st.count_value = cur + 8'h01;
            end
        end

        // a mode change into a narrower range pulls the count inside it at once
        if (wr_lane0 && avs_req.address == `TBP_ADDR_MODE) begin
            nxt_st.count_value = nxt_st.count_value & range_mask(nxt_st.mode);
        end

        // leaving 0xFF sets the flag whatever the cause; set beats a clear
        flag_set = (st_ff.count_value == `TBP_COUNT_TOP &&
                    nxt_st.count_value != `TBP_COUNT_TOP) || wrap;
        if (flag_set) begin
            nxt_st.overflow_irq_flag = 1'h1;
        end

        if (nxt_st.mode.counter_enable && !st_ff.mode.counter_enable) begin
            nxt_st.toggle_lvl = 1'h0;
        end else if (wrap && !st_ff.mode.pwm_output_enable) begin
            nxt_st.toggle_lvl = !st_ff.toggle_lvl;
        end

        // compare taken from next count so the pin tracks the count without lag
        nxt_st.pwm_lvl = nxt_st.mode.counter_enable && nxt_st.mode.pwm_output_enable &&
                         ((nxt_st.count_value & range_mask(nxt_st.mode)) <
                          (nxt_st.reload_compare_value & range_mask(nxt_st.mode)));

        if (nxt_st.mode.pwm_output_enable) begin
            nxt_st.pin.pin_out = nxt_st.pwm_lvl;
        end else if (nxt_st.mode.timer_toggle_out) begin
            nxt_st.pin.pin_out = nxt_st.toggle_lvl;
        end else begin
            nxt_st.pin.pin_out = 1'h0;
        end
        nxt_st.pin.gpio_suppress = nxt_st.mode.pwm_output_enable ||
                                   nxt_st.mode.timer_toggle_out;
        nxt_st.pin.pin_oe_n      = !nxt_st.pin.gpio_suppress;
        nxt_st.pin.irq_req       = nxt_st.overflow_irq_flag &&
                                   nxt_st.overflow_irq_enable;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff                      <= '0;
            st_ff.mode                 <= `TBP_MODE_RESET;
            st_ff.count_value          <= `TBP_COUNT_RESET;
            st_ff.reload_compare_value <= `TBP_COMPARE_RESET;
            st_ff.rsp.waitrequest      <= 1'h1;
            st_ff.pin.pin_oe_n         <= 1'h1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_rsp = st_ff.rsp;
    assign pin     = st_ff.pin;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_TOGGLE_ON_WRAP: assert property (
        (tick && cur == mask && !st_ff.mode.pwm_output_enable && !wr_lane0
         && st_ff.mode.counter_enable && $past(st_ff.mode.counter_enable))
        |=> (st_ff.toggle_lvl != $past(st_ff.toggle_lvl)))
        else $error("toggle level did not invert on overflow");

    AST_PIN_OWNED: assert property (
        (st_ff.mode.timer_toggle_out || st_ff.mode.pwm_output_enable)
        |-> (!pin.pin_oe_n && pin.gpio_suppress))
        else $error("shared pin not taken over");

    AST_HALT: assert property (
        !st_ff.mode.counter_enable
        ##1 (!st_ff.mode.counter_enable && !$past(wr_lane0))
        |-> $stable(st_ff.count_value) && !st_ff.pwm_lvl)
        else $error("counter moved or pwm high while disabled");

    AST_FLAG_LEAVE_TOP: assert property (
        (st_ff.count_value == 8'hFF) ##1 (st_ff.count_value != 8'hFF)
        |-> st_ff.overflow_irq_flag)
        else $error("flag not set after count left 0xFF");

    AST_IRQ_NEXT: assert property (
        (st_ff.overflow_irq_flag && st_ff.overflow_irq_enable)
        |-> pin.irq_req)
        else $error("interrupt request missing while flag and enable set");

    AST_RANGE: assert property (
        st_ff.mode.pwm_output_enable && $stable(st_ff.mode)
        |-> (st_ff.count_value & ~range_mask(st_ff.mode)) == 8'h00)
        else $error("count above modulus in pwm mode");

    AST_PWM_CMP: assert property (
        st_ff.mode.counter_enable && st_ff.mode.pwm_output_enable
        |-> pin.pin_out == ((st_ff.count_value & mask) <
                            (st_ff.reload_compare_value & mask)))
        else $error("pwm pin disagrees with compare");

    AST_PWM_WRAP_FLAG: assert property (
        tick && !wr_lane0 && st_ff.mode.pwm_output_enable && cur == mask
        |=> st_ff.overflow_irq_flag && st_ff.count_value == 8'h00)
        else $error("pwm period end without flag");

    AST_RELOAD: assert property (
        tick && !wr_lane0 && cur == mask && !st_ff.mode.pwm_output_enable
        && st_ff.mode.reload_or_range_bit
        |=> st_ff.count_value == $past(st_ff.reload_compare_value))
        else $error("reload value not copied on overflow");

    AST_TOGGLE_START_LOW: assert property (
        $rose(st_ff.mode.counter_enable) |-> !st_ff.toggle_lvl)
        else $error("toggle level not low at enable");

    AST_BUS_ANSWER: assert property (
        req && st_ff.rsp.waitrequest |=> !st_ff.rsp.waitrequest ##1 st_ff.rsp.waitrequest)
        else $error("bus answer not one cycle after request");

    AST_PWM_LOW_AT_MATCH: assert property (
        st_ff.mode.counter_enable && st_ff.mode.pwm_output_enable
        && (st_ff.count_value & mask) == (st_ff.reload_compare_value & mask)
        |-> !pin.pin_out)
        else $error("pwm pin high at compare match");

    AST_PWM_HIGH_AT_ZERO: assert property (
        st_ff.mode.counter_enable && st_ff.mode.pwm_output_enable
        && (st_ff.count_value & mask) == 8'h00
        && (st_ff.reload_compare_value & mask) != 8'h00
        |-> pin.pin_out)
        else $error("pwm pin not high at count zero");

    AST_PWM_ROUTE: assert property (
        st_ff.mode.pwm_output_enable
        |-> (!pin.pin_oe_n && pin.gpio_suppress && pin.pin_out == st_ff.pwm_lvl))
        else $error("pwm waveform not on shared pin");

    AST_TOGGLE_ROUTE: assert property (
        !st_ff.mode.pwm_output_enable && st_ff.mode.timer_toggle_out
        |-> pin.pin_out == st_ff.toggle_lvl)
        else $error("toggle level not on shared pin");

    AST_PIN_FREE: assert property (
        !st_ff.mode.pwm_output_enable && !st_ff.mode.timer_toggle_out
        |-> (pin.pin_oe_n && !pin.gpio_suppress && !pin.pin_out))
        else $error("shared pin held with both outputs off");

    AST_COUNT_WRITE: assert property (
        wr_lane0 && avs_req.address == `TBP_ADDR_COUNT
        |=> st_ff.count_value == ($past(wr_byte) & $past(mask)))
        else $error("count write not applied at once");

    AST_MODE_WRITE: assert property (
        wr_lane0 && avs_req.address == `TBP_ADDR_MODE
        |=> st_ff.mode == $past(wr_byte))
        else $error("mode write not stored");

    AST_EXT_ONLY: assert property (
        st_ff.mode.counter_enable && st_ff.mode.clock_source_select && !ext_fall && !wr_lane0
        |=> $stable(st_ff.count_value))
        else $error("count moved without an external falling edge");

    AST_NO_RANGE_OFF_PWM: assert property (
        tick && !wr_lane0 && !st_ff.mode.pwm_output_enable && cur != 8'hFF
        |=> st_ff.count_value == $past(cur) + 8'h01)
        else $error("range bits acted outside pwm mode");

    AST_HALT_TOGGLE: assert property (
        !st_ff.mode.counter_enable ##1 !st_ff.mode.counter_enable
        |-> $stable(st_ff.toggle_lvl))
        else $error("toggle level moved while disabled");

    AST_READ_COUNT: assert property (
        avs_req.read && st_ff.rsp.waitrequest && avs_req.address == `TBP_ADDR_COUNT
        |=> st_ff.rsp.readdata == {24'h000000, $past(st_ff.count_value)})
        else $error("read data not the count at request");
endmodule
`default_nettype wire

// *** hw/tbp_params.svh ***
// Function
// - buzzer mode inverts toggle output on every overflow, halving overflow rate.
// - enabled toggle output owns the shared pin and suppresses its general I/O.
// - clearing counter enable halts counting and stops toggle and PWM outputs.
// - overflow flag sets whenever count leaves 0xFF, even by write or disabled.
// - pending flag plus newly set enable raises the interrupt on the next cycle.
// - PWM mode counts modulo 256, 64, 32 or 16 from reload and toggle bits.
// - range 00=256, 01=64, 10=32, 11=16; count and compare limited to modulus-1.
// - PWM output is high while count is below compare value, else low.
// - PWM goes low when count equals compare, and high when count wraps to zero if compare is nonzero.
// - PWM high ratio equals compare value over modulus, zero up to modulus-1.
// - PWM enable routes the PWM waveform to the shared pin, suppressing its I/O.
// - a compare write in PWM mode changes the duty immediately.
// - in PWM mode the overflow flag rises once per PWM period.
// - auto-reload outside PWM mode copies compare value into count on overflow.
// - mode register: enable b7, prescale b6:4, source b3, reload b2, toggle b1, pwm b0.
// - external source counts falling edges of the external input; prescale ignored.
// - reload and toggle bits mean their normal things only while PWM is off.
`ifndef TBP_PARAMS_SVH
`define TBP_PARAMS_SVH

`define TBP_ADDR_MODE      5'h00
`define TBP_ADDR_COUNT     5'h04
`define TBP_ADDR_COMPARE   5'h08
`define TBP_ADDR_IRQ       5'h0C
`define TBP_ADDR_STATUS    5'h10

`define TBP_MODE_RESET     8'h00
`define TBP_COUNT_RESET    8'h00
`define TBP_COMPARE_RESET  8'h00
`define TBP_COUNT_TOP      8'hFF

`define TBP_IRQ_FLAG_BIT   0
`define TBP_IRQ_EN_BIT     1
`define TBP_ST_TOGGLE_BIT  0
`define TBP_ST_PWM_BIT     1
`define TBP_ST_PIN_BIT     2

`define TBP_MASK_256       8'hFF
`define TBP_MASK_64        8'h3F
`define TBP_MASK_32        8'h1F
`define TBP_MASK_16        8'h0F

`endif

// *** hw/tbp_pkg.sv ***
package tbp_pkg;

    typedef struct packed {
        logic       counter_enable;
        logic [2:0] prescale_select;
        logic       clock_source_select;
        logic       reload_or_range_bit;
        logic       timer_toggle_out;
        logic       pwm_output_enable;
    } tbp_mode_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } tbp_bus_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } tbp_bus_rsp_t;

    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
        logic gpio_suppress;
        logic irq_req;
    } tbp_pin_t;

endpackage

// *** hw/tbp_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
module tbp_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [2:0] rate,
    output logic            tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tbp_pre_st_t;

    tbp_pre_st_t st_ff;
    tbp_pre_st_t nxt_st;
    logic [7:0]  mask;

    // 000 divides by 256, 111 by 2
    assign mask = 8'hFF >> rate;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.cnt  = run ? st_ff.cnt + 8'h01 : 8'h00;
        nxt_st.tick = run && ((st_ff.cnt & mask) == mask);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule
`default_nettype wire

// *** hw/tbp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module tbp_sync (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic fall;
    } tbp_sync_st_t;

    tbp_sync_st_t st_ff;
    tbp_sync_st_t nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.s1    = pin_in;
        nxt_st.s2    = st_ff.s1;
        nxt_st.s3    = st_ff.s2;
        nxt_st.fall  = 1'h0;
        // a change counts only once stages two and three agree
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.level = st_ff.s3;
            nxt_st.fall  = st_ff.level && !st_ff.s3;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= 5'h1E;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fall = st_ff.fall;
endmodule
`default_nettype wire

// *** tb/tbp_pin_load.sv ***
`timescale 1ns/10ps
`default_nettype none
module tbp_pin_load (
    input  wire logic              sys_clk,
    input  wire tbp_pkg::tbp_pin_t pin,
    output logic                   level,
    output int                     edges
);
    import tbp_pkg::*;
    // released pin floats to the pull-up, never keeps the last driven level
    assign level = pin.pin_oe_n ? 1'b1 : pin.pin_out;
    initial edges = 0;
    always @(level) begin
        edges++;
    end
endmodule
`default_nettype wire

// *** tb/tbp_timer_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tbp_params.svh"
module tbp_timer_test;
    import tbp_pkg::*;
    logic         sys_clk = 1'b0;
    logic         nrst;
    tbp_bus_req_t req;
    tbp_bus_rsp_t rsp;
    logic         ext_in;
    tbp_pin_t     pin;
    logic         level;
    int           edges;
    int           failures;
    int           total_checks;
    logic [7:0]   q;
    logic [7:0]   keep;
    logic         lv;
    logic [1:0]   rr;
    int           e0;
    int           h;
    int           cmp;
    int           md;
    int           n;

    always #20 sys_clk = ~sys_clk;

    tbp_timer dut_u (
        .sys_clk         (sys_clk),
        .nrst            (nrst),
        .avs_req         (req),
        .avs_rsp         (rsp),
        .ext_count_input (ext_in),
        .pin             (pin)
    );

    tbp_pin_load load_u (
        .sys_clk (sys_clk),
        .pin     (pin),
        .level   (level),
        .edges   (edges)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // one Avalon access; waitrequest and read data are taken at the rising edge
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        req.write <= wr;
        req.read <= ~wr;
        req.address <= a;
        req.writedata <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rsp.waitrequest !== 1'b0 && k < 50);
        if (k >= 50) chk(16'h0000, 16'h0001, "bus answer missing");
        q = rsp.readdata[7:0];
        req.write <= 1'b0;
        req.read <= 1'b0;
        // outputs launched by this edge settle before callers look at them
        @(negedge sys_clk);
    endtask

    function automatic int modulus(input int r);
        return (r == 0) ? 256 : (128 >> r);
    endfunction

    // whole periods in the window make the count independent of phase
    function automatic int exp_highs(input int c);
        return 4 * c;
    endfunction

    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        req = '0;
        req.byteenable = 4'hF;
        ext_in = 1'b1;
        failures = 0;
        total_checks = 0;
        void'($urandom(55));
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        chk(rsp.waitrequest, 1'b1, "idle wait");
        chk(pin.pin_oe_n, 1'b1, "pin released");
        chk(pin.gpio_suppress, 1'b0, "gpio free");
        xfer(1'b0, `TBP_ADDR_MODE, 8'h00);
        chk(q, `TBP_MODE_RESET, "mode reset");
        xfer(1'b0, 5'h14, 8'h00);
        chk(q, 8'h00, "unmapped read");
        xfer(1'b0, `TBP_ADDR_COMPARE, 8'h00);
        chk(q, 8'h00, "compare write-only");
        xfer(1'b1, `TBP_ADDR_IRQ, 8'h00);
        xfer(1'b1, `TBP_ADDR_COUNT, 8'hFF);
        xfer(1'b1, `TBP_ADDR_COUNT, 8'h00);
        xfer(1'b0, `TBP_ADDR_IRQ, 8'h00);
        chk(q[0], 1'b1, "flag on leaving FF");
        chk(pin.irq_req, 1'b0, "no irq while disabled");
        xfer(1'b1, `TBP_ADDR_IRQ, 8'h03);
        repeat (2) @(negedge sys_clk);
        chk(pin.irq_req, 1'b1, "pending irq on enable");
        xfer(1'b1, `TBP_ADDR_IRQ, 8'h00);
        xfer(1'b1, `TBP_ADDR_COMPARE, 8'hF0);
        xfer(1'b1, `TBP_ADDR_COUNT, 8'hF0);
        xfer(1'b1, `TBP_ADDR_MODE, 8'hF6);
        chk(pin.gpio_suppress, 1'b1, "toggle owns pin");
        chk(pin.pin_oe_n, 1'b0, "toggle drives pin");
        repeat (64) @(negedge sys_clk);
        e0 = edges;
        repeat (224) @(negedge sys_clk);
        chk(16'(edges - e0), 16'd7, "toggle per reload wrap");
        xfer(1'b1, `TBP_ADDR_MODE, 8'h76);
        lv = pin.pin_out;
        xfer(1'b0, `TBP_ADDR_COUNT, 8'h00);
        keep = q;
        repeat (50) @(negedge sys_clk);
        xfer(1'b0, `TBP_ADDR_COUNT, 8'h00);
        chk(q, keep, "count halted");
        chk(pin.pin_out, lv, "toggle held");
        xfer(1'b0, `TBP_ADDR_STATUS, 8'h00);
        chk(q[2:0], {lv, 1'b0, lv}, "status levels");
        xfer(1'b1, `TBP_ADDR_COUNT, 8'hF0);
        xfer(1'b1, `TBP_ADDR_MODE, 8'hF6);
        repeat (3) @(negedge sys_clk);
        chk(pin.pin_out, 1'b0, "toggle starts low");
        for (int r = 0; r < 4; r++) begin
            rr = 2'(r);
            md = modulus(r);
            cmp = (r == 3) ? 0 : int'($urandom % md);
            xfer(1'b1, `TBP_ADDR_MODE, {1'b0, 3'b111, 1'b0, rr, 1'b1});
            xfer(1'b1, `TBP_ADDR_COUNT, 8'h00);
            xfer(1'b1, `TBP_ADDR_COMPARE, 8'(cmp));
            xfer(1'b1, `TBP_ADDR_MODE, {1'b1, 3'b111, 1'b0, rr, 1'b1});
            chk(pin.gpio_suppress, 1'b1, "pwm owns pin");
            repeat (2 * md) @(negedge sys_clk);
            h = 0;
            repeat (4 * md) begin
                @(negedge sys_clk);
                h += int'(pin.pin_out === 1'b1);
            end
            chk(16'(h), 16'(exp_highs(cmp)), "pwm high time");
            xfer(1'b1, `TBP_ADDR_IRQ, 8'h00);
            repeat (2 * md + 4) @(negedge sys_clk);
            xfer(1'b0, `TBP_ADDR_IRQ, 8'h00);
            chk(q[0], 1'b1, "flag each pwm period");
        end
        xfer(1'b1, `TBP_ADDR_MODE, 8'h00);
        xfer(1'b1, `TBP_ADDR_COUNT, 8'h00);
        // fast internal rate selected so a leak of prescaler ticks would show
        xfer(1'b1, `TBP_ADDR_MODE, 8'hF8);
        n = 3 + int'($urandom % 5);
        repeat (n) begin
            @(posedge sys_clk);
            ext_in <= 1'b0;
            repeat (6) @(posedge sys_clk);
            ext_in <= 1'b1;
            repeat (6) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        xfer(1'b0, `TBP_ADDR_COUNT, 8'h00);
        chk(q, 8'(n), "external falling edges");
        give_verdict();
    end
endmodule
`default_nettype wire
